// >>> rtl/fan_ramp_defs.svh
// register offsets, field positions, reset value and ramp timing for the fan ramp smoother
// assumes a 50 mhz aclk and an 8-bit duty code (0x00 = 0%, 0xff = 100%)
`ifndef FAN_RAMP_DEFS_SVH
`define FAN_RAMP_DEFS_SVH

// printed offset 0x63 is not a multiple of four: kept as an index, byte address is four times it
`define RAMP_CTRL_IDX 8'h63
`define RAMP_CTRL_ADDR 12'h18c
// own control word: bit0 lock, bit1 slow timing scale
`define RAMP_CFG_ADDR 12'h000
// own status word: local duty [7:0], remote2 duty [15:8]
`define RAMP_STAT_ADDR 12'h004
`define RAMP_CTRL_RESET 8'h00
`define CFG_LOCK_BIT 0
`define CFG_SLOW_BIT 1
`define LOCAL_RATE_LSB 0
`define LOCAL_EN_BIT 3
`define REMOTE2_RATE_LSB 4
`define REMOTE2_EN_BIT 7
// one duty step per slot; 37.5 s sweep of 255 steps at slot increment 1
`define CLK_HZ 50000000
`define SWEEP_FAST_MS 37500
`define SWEEP_SLOW_MS 52200
`define DUTY_STEPS 255
// worked out in 64 bits: the slow product would overflow a 32-bit int
`define SLOT_FAST_CYC int'(64'(`CLK_HZ / 1000) * 64'(`SWEEP_FAST_MS) / 64'(`DUTY_STEPS))
`define SLOT_SLOW_CYC int'(64'(`CLK_HZ / 1000) * 64'(`SWEEP_SLOW_MS) / 64'(`DUTY_STEPS))

`endif

// >>> rtl/fan_ramp_pkg.sv
// types shared by the fan ramp smoother
// assumes nothing beyond the defs header
package fan_ramp_pkg;
   typedef struct packed
   {
      logic remote2_smooth_enable;
      logic [2:0] remote2_ramp_rate;
      logic local_smooth_enable;
      logic [2:0] local_ramp_rate;
   } ramp_ctrl_t;

   typedef enum logic [1:0] {resp_okay = 2'b00, resp_slverr = 2'b10} axi_resp_t;
endpackage

// >>> rtl/ramp_limiter.sv
// one channel of duty-cycle slew limiting
// assumes slot_tick is a one-cycle enable from the shared divider
module ramp_limiter #(
   parameter int DUTY_W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slot_tick,
   input wire logic smooth_enable,
   input wire logic [2:0] ramp_rate,
   input wire logic [DUTY_W-1:0] target_duty,
   output logic [DUTY_W-1:0] duty_r
);
   logic [DUTY_W-1:0] step;
   logic [DUTY_W-1:0] duty_nxt;

   // rate code to slot increment
   always_comb
   begin
      unique case (ramp_rate)
         3'd0: step = DUTY_W'(1);
         3'd1: step = DUTY_W'(2);
         3'd2: step = DUTY_W'(3);
         3'd3: step = DUTY_W'(4);
         3'd4: step = DUTY_W'(8);
         3'd5: step = DUTY_W'(12);
         3'd6: step = DUTY_W'(24);
         3'd7: step = DUTY_W'(48);
      endcase
   end

   // with smoothing on, move toward the target by at most one increment per slot, never overshoot; with it off, take the target directly
   always_comb
   begin
      duty_nxt = duty_r;
      if (!smooth_enable)
         duty_nxt = target_duty;
      else if (slot_tick)
      begin
         if (target_duty > duty_r)
            duty_nxt = (target_duty - duty_r > step) ? duty_r + step : target_duty;
         else if (target_duty < duty_r)
            duty_nxt = (duty_r - target_duty > step) ? duty_r - step : target_duty;
      end
   end

   // output duty register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         duty_r <= '0;
      else
         duty_r <= duty_nxt;
   end

   a_bypass_follows: assert property (@(posedge aclk) disable iff (!aresetn)
      !smooth_enable |=> duty_r == $past(target_duty))
      else $error("duty did not follow target with smoothing off");
   a_hold_between_slots: assert property (@(posedge aclk) disable iff (!aresetn)
      smooth_enable && !slot_tick |=> $stable(duty_r))
      else $error("duty moved between slots");
   a_step_bounded: assert property (@(posedge aclk) disable iff (!aresetn)
      smooth_enable && slot_tick && target_duty > duty_r
      |=> duty_r > $past(duty_r) && duty_r - $past(duty_r) <= $past(step))
      else $error("duty step out of bound");
endmodule

// >>> rtl/fan_ramp_smoother.sv
// fan duty ramp smoother for the local and remote 2 channels with axi4-lite registers
// assumes same-clock target duties from the fan control loop and a single aclk
//
// Contract
// - lock bit set makes ramp register read-only
// - ramp register resets to zero
// - local rate field bits 2:0 limits ramp
// - scale 0: increments 1..48, 37.5 s sweep
// - scale 1: sweeps from 52.2 s down
// - bit 3 enables local smoothing
// - remote2 rate field bits 6:4, same encoding
// - bit 7 enables remote2 smoothing
//
// The AXI4-Lite interface to the registers was decided locally.
`include "fan_ramp_defs.svh"
module fan_ramp_smoother #(
   parameter int DUTY_W = 8,
   parameter int SLOT_FAST = `SLOT_FAST_CYC,
   parameter int SLOT_SLOW = `SLOT_SLOW_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [DUTY_W-1:0] local_target_duty,
   input wire logic [DUTY_W-1:0] remote2_target_duty,
   output logic [DUTY_W-1:0] local_fan_drive_output,
   output logic [DUTY_W-1:0] remote2_fan_drive_output
);
   fan_ramp_pkg::ramp_ctrl_t ramp_ctrl_r;
   logic lock_r;
   logic slow_scale_r;
   logic aw_held_r;
   logic w_held_r;
   logic [11:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic wr_fire;
   logic [31:0] slot_cnt_r;
   logic [31:0] slot_len;
   logic slot_tick;
   logic [31:0] rdata_nxt;
   logic [1:0] rresp_nxt;
   logic [31:0] tick_gap_r;
   logic scale_seen_r;
   logic scale_moved_r;
   // word indices of the three registers, matched against address bits 11:2
   localparam logic [9:0] CTRL_WORD = 10'(`RAMP_CTRL_ADDR >> 2);
   localparam logic [9:0] CFG_WORD = 10'(`RAMP_CFG_ADDR >> 2);
   localparam logic [9:0] STAT_WORD = 10'(`RAMP_STAT_ADDR >> 2);

   // write address and data are taken independently, each held until the pair is complete
   assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
   assign s_axi_wready = !w_held_r && !s_axi_bvalid;
   assign wr_fire = aw_held_r && w_held_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wdata_r <= s_axi_wdata;
         wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
         w_held_r <= 1'b0;
   end

   // write response: slverr for unmapped addresses, okay otherwise (a locked write is silently dropped)
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= fan_ramp_pkg::resp_okay;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         if (awaddr_r[11:2] == CTRL_WORD || awaddr_r[11:2] == CFG_WORD
             || awaddr_r[11:2] == STAT_WORD)
            s_axi_bresp <= fan_ramp_pkg::resp_okay;
         else
            s_axi_bresp <= fan_ramp_pkg::resp_slverr;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ramp control register, frozen once locked
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ramp_ctrl_r <= `RAMP_CTRL_RESET;
      else if (wr_fire && awaddr_r[11:2] == CTRL_WORD && wstrb_r[0] && !lock_r)
         ramp_ctrl_r <= wdata_r[7:0];
   end

   // lock and timing scale; lock is sticky until reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         lock_r <= 1'b0;
         slow_scale_r <= 1'b0;
      end
      else if (wr_fire && awaddr_r[11:2] == CFG_WORD && wstrb_r[0])
      begin
         lock_r <= lock_r | wdata_r[`CFG_LOCK_BIT];
         slow_scale_r <= wdata_r[`CFG_SLOW_BIT];
      end
   end

   // slot divider: one-cycle tick per slot, length picked by the timing scale
   assign slot_len = slow_scale_r ? 32'(SLOT_SLOW) : 32'(SLOT_FAST);
   assign slot_tick = (slot_cnt_r >= slot_len - 32'h0000_0001);

   always_ff @(posedge aclk)
   begin
      if (!aresetn || slot_tick)
         slot_cnt_r <= 32'h0000_0000;
      else
         slot_cnt_r <= slot_cnt_r + 32'h0000_0001;
   end

   // assertion helpers: cycles since the last tick, and whether the scale moved inside the slot
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_gap_r <= 32'h0000_0000;
         scale_seen_r <= 1'b0;
         scale_moved_r <= 1'b0;
      end
      else
      begin
         scale_seen_r <= slow_scale_r;
         if (slot_tick)
         begin
            tick_gap_r <= 32'h0000_0000;
            scale_moved_r <= 1'b0;
         end
         else
         begin
            tick_gap_r <= tick_gap_r + 32'h0000_0001;
            scale_moved_r <= scale_moved_r | (scale_seen_r != slow_scale_r);
         end
      end
   end

   // read data mux
   always_comb
   begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = fan_ramp_pkg::resp_okay;
      if (s_axi_araddr[11:2] == CTRL_WORD)
         rdata_nxt[7:0] = ramp_ctrl_r;
      else if (s_axi_araddr[11:2] == CFG_WORD)
      begin
         rdata_nxt[`CFG_LOCK_BIT] = lock_r;
         rdata_nxt[`CFG_SLOW_BIT] = slow_scale_r;
      end
      else if (s_axi_araddr[11:2] == STAT_WORD)
      begin
         rdata_nxt[7:0] = 8'(local_fan_drive_output);
         rdata_nxt[15:8] = 8'(remote2_fan_drive_output);
      end
      else
         rresp_nxt = fan_ramp_pkg::resp_slverr;
   end

   assign s_axi_arready = !s_axi_rvalid;

   // read channel: data registered one cycle after the address is taken
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= fan_ramp_pkg::resp_okay;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rresp_nxt;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // local channel limiter
   ramp_limiter #(.DUTY_W(DUTY_W)) local_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .slot_tick(slot_tick),
      .smooth_enable(ramp_ctrl_r.local_smooth_enable),
      .ramp_rate(ramp_ctrl_r.local_ramp_rate),
      .target_duty(local_target_duty),
      .duty_r(local_fan_drive_output)
   );

   // remote 2 channel limiter
   ramp_limiter #(.DUTY_W(DUTY_W)) remote2_ramp (
      .aclk(aclk),
      .aresetn(aresetn),
      .slot_tick(slot_tick),
      .smooth_enable(ramp_ctrl_r.remote2_smooth_enable),
      .ramp_rate(ramp_ctrl_r.remote2_ramp_rate),
      .target_duty(remote2_target_duty),
      .duty_r(remote2_fan_drive_output)
   );

   // register behaviour: lock, reset value, locked writes
   a_lock_freezes: assert property (@(posedge aclk) disable iff (!aresetn)
      lock_r |=> $stable(ramp_ctrl_r))
      else $error("ramp register changed while locked");
   a_lock_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
      lock_r |=> lock_r)
      else $error("lock bit cleared without reset");
   a_locked_write_ok: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire && lock_r && awaddr_r[11:2] == CTRL_WORD
      |=> s_axi_bvalid && s_axi_bresp == fan_ramp_pkg::resp_okay)
      else $error("locked write not answered okay");
   a_reset_zero: assert property (@(posedge aclk)
      !aresetn |=> ramp_ctrl_r == 8'h00)
      else $error("ramp register not zero after reset");
   // slot timing: tick spacing measured by the helper counter, slots with a scale change left out
   a_fast_slot_len: assert property (@(posedge aclk) disable iff (!aresetn)
      slot_tick && !slow_scale_r && !scale_moved_r && scale_seen_r == slow_scale_r
      |-> tick_gap_r == 32'(SLOT_FAST) - 32'h0000_0001)
      else $error("fast slot length wrong");
   a_slow_slot_len: assert property (@(posedge aclk) disable iff (!aresetn)
      slot_tick && slow_scale_r && !scale_moved_r && scale_seen_r == slow_scale_r
      |-> tick_gap_r == 32'(SLOT_SLOW) - 32'h0000_0001)
      else $error("slow slot length wrong");
   a_tick_single: assert property (@(posedge aclk) disable iff (!aresetn)
      slot_tick |=> !slot_tick)
      else $error("slot tick longer than one cycle");
   // duty path with smoothing off
   a_local_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      !ramp_ctrl_r.local_smooth_enable |=> local_fan_drive_output == $past(local_target_duty))
      else $error("local duty not immediate with smoothing off");
   a_remote2_enable: assert property (@(posedge aclk) disable iff (!aresetn)
      !ramp_ctrl_r.remote2_smooth_enable |=> remote2_fan_drive_output == $past(remote2_target_duty))
      else $error("remote2 duty not immediate with smoothing off");
   // bus answers
   a_rvalid_next: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_bvalid_next: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write answer late");
   a_busy_refuses: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_unmapped_read: assert property (@(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] != CTRL_WORD && s_axi_araddr[11:2] != CFG_WORD
      && s_axi_araddr[11:2] != STAT_WORD |=> s_axi_rresp == fan_ramp_pkg::resp_slverr)
      else $error("unmapped read not answered with slave error");

   // main scenarios
   c_locked_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire && lock_r);
   c_local_ramp: cover property (@(posedge aclk) disable iff (!aresetn)
      slot_tick && ramp_ctrl_r.local_smooth_enable && local_target_duty != local_fan_drive_output);
   c_remote2_ramp: cover property (@(posedge aclk) disable iff (!aresetn)
      slot_tick && ramp_ctrl_r.remote2_smooth_enable && remote2_target_duty != remote2_fan_drive_output);
   c_slow_tick: cover property (@(posedge aclk) disable iff (!aresetn) slot_tick && slow_scale_r);
endmodule

// >>> tb/fan_model.sv
// behavioural fan that follows the drive duty with mechanical lag
// assumes one duty code per channel from the smoother, same aclk
module fan_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] duty,
   output logic [7:0] speed_r
);
   timeunit 1ns;
   timeprecision 1ps;
   // rotor speed creeps one code per cycle toward the drive, so a jump shows as a ramp
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         speed_r <= 8'h00;
      else if (speed_r < duty)
         speed_r <= speed_r + 8'h01;
      else if (speed_r > duty)
         speed_r <= speed_r - 8'h01;
   end
endmodule

// >>> tb/testbench.sv
// self-checking bench for the fan ramp smoother: axi4-lite tasks and duty ramp scenarios
// assumes short slot lengths of 4 and 6 cycles and the defs header on the include path
`include "fan_ramp_defs.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SF = 4;
   localparam int SS = 6;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000, araddr = 12'h000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] loc_tgt = 8'h00, rem_tgt = 8'h00, loc_out, rem_out, loc_spd, rem_spd;
   logic [31:0] rd;
   fan_ramp_pkg::ramp_ctrl_t rc;
   int bad_count = 0, checks_done = 0, cyc;
   int steps[8] = '{1, 2, 3, 4, 8, 12, 24, 48};
   fan_ramp_smoother #(.DUTY_W(8), .SLOT_FAST(SF), .SLOT_SLOW(SS)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .local_target_duty(loc_tgt), .remote2_target_duty(rem_tgt),
      .local_fan_drive_output(loc_out), .remote2_fan_drive_output(rem_out));
   fan_model fan_loc (.aclk(aclk), .aresetn(aresetn), .duty(loc_out), .speed_r(loc_spd));
   fan_model fan_rem (.aclk(aclk), .aresetn(aresetn), .duty(rem_out), .speed_r(rem_spd));
   // 50 mhz clock
   always #10 aclk = ~aclk;
   // verdict and end of run
   task automatic close_out();
      if (bad_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // compare one value and count it
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // axi4-lite write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!bvalid)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      r = bresp;
      bready <= 1'b0;
   endtask
   // axi4-lite read: address held until taken, data taken with rvalid
   task automatic axi_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!rvalid)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
   // count cycles until the local drive output moves
   task automatic wait_move(output int c);
      logic [7:0] old;
      old = loc_out;
      c = 0;
      do
      begin
         @(negedge aclk);
         c++;
      end
      while (loc_out === old && c < 100);
   endtask
   // watchdog against a hang
   initial
   begin
      #200000;
      bad_count++;
      close_out();
   end
   // main sequence
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`RAMP_CTRL_ADDR, rd, resp);
      check(rd, 32'h0000_0000);
      check(32'(resp), 32'(fan_ramp_pkg::resp_okay));
      // rate codes under both timing scales, local and remote2 with opposite codes
      for (int s = 0; s < 2; s++)
      begin
         axi_wr(`RAMP_CFG_ADDR, 32'(s) << `CFG_SLOW_BIT, resp);
         for (int k = 0; k < 8; k++)
         begin
            axi_wr(`RAMP_CTRL_ADDR, 32'h0000_0000, resp);
            @(posedge aclk);
            loc_tgt <= 8'h00;
            rem_tgt <= 8'h00;
            repeat (3) @(negedge aclk);
            check(loc_out, 32'h0000_0000);
            rc = '{1'b1, 3'(7 - k), 1'b1, 3'(k)};
            axi_wr(`RAMP_CTRL_ADDR, {24'h00_0000, rc}, resp);
            @(posedge aclk);
            loc_tgt <= 8'hff;
            rem_tgt <= 8'hff;
            wait_move(cyc);
            check(loc_out, 32'(steps[k]));
            check(rem_out, 32'(steps[7 - k]));
            wait_move(cyc);
            check(32'(cyc), s ? 32'(SS) : 32'(SF));
            check(loc_out, 32'(2 * steps[k]));
         end
      end
      // smoothing off jumps straight to the target
      axi_wr(`RAMP_CTRL_ADDR, 32'h0000_0000, resp);
      repeat (2) @(negedge aclk);
      check(loc_out, 32'h0000_00ff);
      check(rem_out, 32'h0000_00ff);
      axi_rd(`RAMP_STAT_ADDR, rd, resp);
      check(rd, 32'h0000_ffff);
      // the fans settle at full speed once the drive has stood at full long enough
      repeat (260) @(negedge aclk);
      check(loc_spd, 32'h0000_00ff);
      check(rem_spd, 32'h0000_00ff);
      // lock freezes the ramp register
      axi_wr(`RAMP_CTRL_ADDR, 32'h0000_005a, resp);
      axi_wr(`RAMP_CFG_ADDR, 32'h0000_0001 << `CFG_LOCK_BIT, resp);
      axi_wr(`RAMP_CTRL_ADDR, 32'h0000_00a5, resp);
      check(32'(resp), 32'(fan_ramp_pkg::resp_okay));
      axi_rd(`RAMP_CTRL_ADDR, rd, resp);
      check(rd, 32'h0000_005a);
      axi_rd(`RAMP_CFG_ADDR, rd, resp);
      check(rd, 32'h0000_0001);
      // unmapped place answers slave error
      axi_wr(12'h0f0, 32'h0000_00ff, resp);
      check(32'(resp), 32'(fan_ramp_pkg::resp_slverr));
      axi_rd(12'h0f0, rd, resp);
      check(32'(resp), 32'(fan_ramp_pkg::resp_slverr));
      check(rd, 32'h0000_0000);
      // second reset clears register and lock
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(`RAMP_CTRL_ADDR, rd, resp);
      check(rd, 32'h0000_0000);
      axi_wr(`RAMP_CTRL_ADDR, 32'h0000_0033, resp);
      axi_rd(`RAMP_CTRL_ADDR, rd, resp);
      check(rd, 32'h0000_0033);
      close_out();
   end
endmodule
